/* File: pkg/itm_consts.vh */
// Purpose: Constants for the 16-bit interval timer
// Assumes: AHB-Lite register access, 32-bit data
// Notes: Offsets are byte addresses
`ifndef ITM_CONSTS_VH
`define ITM_CONSTS_VH
// ****************************************
// Register map
// ****************************************
`define ITM_OFS_COMPARE 8'h00
`define ITM_OFS_CONTROL 8'h04
`define ITM_OFS_STATUS 8'h08
// ****************************************
// Fields and resets
// ****************************************
`define ITM_CTL_RUN 7
`define ITM_CTL_CKS_HI 2
`define ITM_CTL_CKS_LO 0
`define ITM_CTL_MASK 8'h87
`define ITM_CMP_RESET 16'h0000
`define ITM_CTL_RESET 8'h00
`define ITM_CNT_START 16'hFFFF
// ****************************************
// Clock select codes and divider taps
// ****************************************
`define ITM_CKS_MAIN 3'h0
`define ITM_CKS_DIV2 3'h1
`define ITM_CKS_DIV4 3'h2
`define ITM_CKS_DIV64 3'h3
`define ITM_CKS_DIV512 3'h4
`define ITM_CKS_WATCH 3'h5
`define ITM_CKS_OSC8 3'h6
`define ITM_CKS_SUB 3'h7
`define ITM_DIV_BITS 9
`define ITM_OSC_DIV_BITS 3
`endif

/* File: rtl/itm_edge_sync.v */
// Purpose: Synchronise an asynchronous clock-like input and give its rising edge
// Assumes: Single clock mclk, synchronous active-low reset
// Notes: First flop feeds only the second flop
module itm_edge_sync (
  input wire mclk, // System clock
  input wire nrst, // Synchronous reset, active low
  input wire asyncIn, // Asynchronous source
  output reg riseOut // One-cycle pulse per rising edge
);
  reg meta;
  reg sync;
  reg syncDly;

  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      syncDly <= 1'b0;
      riseOut <= 1'b0;
    end
    else
    begin
      meta <= asyncIn;
      sync <= meta;
      syncDly <= sync;
      riseOut <= sync & ~syncDly;
    end
  end
endmodule // itm_edge_sync

/* File: rtl/itm_interval_timer.v */
// Purpose: 16-bit clear-and-start interval timer with AHB-Lite registers
// Assumes: mclk is the main clock; osc and subclock inputs are asynchronous
// Notes: Zero wait state slave; counter is internal only
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`include "itm_consts.vh"

// Behaviour
// - Clear-and-start only, no free-run
// - Counter never readable or writable
// - Compare register 16 bits, reset zero
// - Control register 8 bits, reset zero
// - Same-value control writes never disturb operation
// - Run low stops clock, sets counter to all-ones start state
// - Select code picks one of eight clocks
// - Start state all-ones steps to zero
// - At compare value, next edge clears, interrupts
// - Period is compare plus one counts
// - Compare zero interrupts every count clock
// - Counting starts within documented bound
module itm_interval_timer (
  input wire mclk, // Main clock, 25 MHz
  input wire nrst, // Synchronous reset, active low
  input wire hsel, // AHB slave select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output reg [31:0] hrdata, // AHB read data
  output wire hreadyout, // AHB slave ready
  output wire hresp, // AHB response, always OKAY
  input wire watchTickIn, // Watch-timer tick, asynchronous
  input wire internalOscClk, // Internal oscillator clock, asynchronous
  input wire subClk, // Subclock, asynchronous
  output reg matchIrq // Compare-match pulse, one mclk
);
  // ****************************************
  // Bus slave
  // ****************************************
  reg [15:0] intervalCompare;
  reg [7:0] intervalControl;
  reg wrPend;
  reg [7:0] wrAddr;
  reg [2:0] wrSize;
  reg [1:0] wrLane;
  reg [15:0] counter;
  reg counting;

  wire addrPhase = hsel & hready & htrans[1];
  wire timerRun = intervalControl[`ITM_CTL_RUN];
  wire [2:0] clkSel = intervalControl[`ITM_CTL_CKS_HI:`ITM_CTL_CKS_LO];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Byte lane of the control byte within a narrow write
  function laneHit;
    input [2:0] size;
    input [1:0] lane;
    begin
      laneHit = (size == 3'h0) ? (lane == 2'h0) : 1'b1;
    end
  endfunction

  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      wrSize <= 3'h0;
      wrLane <= 2'h0;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wrPend <= addrPhase & hwrite;
      wrAddr <= haddr[7:0];
      wrSize <= hsize;
      wrLane <= haddr[1:0];
      if (addrPhase & ~hwrite)
      begin
        case ({haddr[7:2], 2'b00})
          `ITM_OFS_COMPARE: hrdata <= {16'h0000, intervalCompare};
          `ITM_OFS_CONTROL: hrdata <= {24'h000000, intervalControl};
          `ITM_OFS_STATUS: hrdata <= {31'h00000000, counting};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Registers; compare only as a whole halfword or word
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      intervalCompare <= `ITM_CMP_RESET;
      intervalControl <= `ITM_CTL_RESET;
    end
    else if (wrPend)
    begin
      if ({wrAddr[7:2], 2'b00} == `ITM_OFS_COMPARE && wrSize != 3'h0 && wrLane[0] == 1'b0 && wrLane[1] == 1'b0)
      begin
        intervalCompare <= hwdata[15:0];
      end
      if ({wrAddr[7:2], 2'b00} == `ITM_OFS_CONTROL && laneHit(wrSize, wrLane))
      begin
        intervalControl <= hwdata[7:0] & `ITM_CTL_MASK;
      end
    end
  end

  // ****************************************
  // Count clock sources
  // ****************************************
  reg [`ITM_DIV_BITS-1:0] preDiv;
  wire watchRise;
  wire oscRise;
  wire subRise;
  reg [`ITM_OSC_DIV_BITS-1:0] oscDiv;

  // Prescaler runs only with the timer enabled; gated clock held low otherwise
  always @(posedge mclk)
  begin
    if (!nrst || !timerRun)
    begin
      preDiv <= {`ITM_DIV_BITS{1'b0}};
      oscDiv <= {`ITM_OSC_DIV_BITS{1'b0}};
    end
    else
    begin
      preDiv <= preDiv + 1'b1;
      if (oscRise)
      begin
        oscDiv <= oscDiv + 1'b1;
      end
    end
  end

  itm_edge_sync uWatchSync (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn(watchTickIn),
    .riseOut(watchRise)
  );

  itm_edge_sync uOscSync (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn(internalOscClk),
    .riseOut(oscRise)
  );

  itm_edge_sync uSubSync (
    .mclk(mclk),
    .nrst(nrst),
    .asyncIn(subClk),
    .riseOut(subRise)
  );

  reg countTick;
  always @*
  begin
    case (clkSel)
      `ITM_CKS_MAIN: countTick = 1'b1;
      `ITM_CKS_DIV2: countTick = (preDiv[0] == 1'b1);
      `ITM_CKS_DIV4: countTick = (preDiv[1:0] == 2'h3);
      `ITM_CKS_DIV64: countTick = (preDiv[5:0] == 6'h3F);
      `ITM_CKS_DIV512: countTick = (preDiv == 9'h1FF);
      `ITM_CKS_WATCH: countTick = watchRise;
      `ITM_CKS_OSC8: countTick = oscRise && (oscDiv == 3'h7);
      `ITM_CKS_SUB: countTick = subRise;
      default: countTick = 1'b0;
    endcase
  end

  // ****************************************
  // Counter and match
  // ****************************************
  wire cntEdge = timerRun & countTick;

  always @(posedge mclk)
  begin
    if (!nrst || !timerRun)
    begin
      counter <= `ITM_CNT_START;
      counting <= 1'b0;
      matchIrq <= 1'b0;
    end
    else
    begin
      matchIrq <= 1'b0;
      if (cntEdge)
      begin
        counting <= 1'b1;
        if (!counting)
        begin
          counter <= 16'h0000;
        end
        else if (counter == intervalCompare)
        begin
          counter <= 16'h0000;
          matchIrq <= 1'b1;
        end
        else
        begin
          counter <= counter + 16'h0001;
        end
      end
    end
  end
endmodule // itm_interval_timer

/* File: sim/itm_chk.sv */
// Purpose: Bus readback and match timing checks
// Assumes: Register-aligned addresses, any transfer size
// Notes: Shadows both registers from writes
module itm_chk (
  input wire mclk, // Clock
  input wire nrst, // Reset
  input wire hsel, // Select
  input wire [31:0] haddr, // Address
  input wire [1:0] htrans, // Transfer
  input wire hwrite, // Write
  input wire [2:0] hsize, // Size
  input wire hready, // Ready
  input wire [31:0] hwdata, // Wdata
  input wire [31:0] hrdata, // Rdata
  input wire matchIrq // Match
);
  timeunit 1ns;
  timeprecision 1ps;
  logic aPh, aWr;
  logic [7:0] aAd, ctl;
  logic [15:0] cmp;
  logic [2:0] aSz;
  wire rd = hsel && hready && htrans[1] && !hwrite;
  always_ff @(posedge mclk)
  begin
    aWr <= hwrite;
    aSz <= hsize;
    aAd <= haddr[7:0];
    aPh <= nrst && hsel && hready && htrans[1];
    if (!nrst)
    begin
      ctl <= 8'h00;
      cmp <= 16'h0000;
    end
    else if (aPh && aWr && aAd == 8'h00 && aSz != 3'h0)
      cmp <= hwdata[15:0];
    else if (aPh && aWr && aAd == 8'h04)
      ctl <= hwdata[7:0] & 8'h87;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  a_cmp_read: assert property (rd && haddr[7:0] == 8'h00 |=> hrdata == {16'h0000, cmp})
    else $error("compare readback");
  a_ctl_read: assert property (rd && haddr[7:0] == 8'h04 |=> hrdata == {24'h0, ctl})
    else $error("control readback");
  a_hidden_count: assert property (rd && haddr[7:0] == 8'h0C |=> hrdata == 32'h0)
    else $error("counter visible");
  a_stop_quiet: assert property (!ctl[7] && !$past(ctl[7], 2) |-> !matchIrq)
    else $error("match while stopped");
  a_main_period: assert property (matchIrq && ctl == 8'h80 && cmp == 16'h0003 |=>
    !matchIrq [*3] ##1 (matchIrq || !ctl[7])) else $error("period wrong");
  a_div2_period: assert property (matchIrq && ctl == 8'h81 && cmp == 16'h0001 |=>
    !matchIrq [*3] ##1 (matchIrq || !ctl[7])) else $error("half clock period");
  a_zero_every: assert property (matchIrq && ctl == 8'h80 && cmp == 16'h0000 |=> matchIrq || !ctl[7])
    else $error("zero compare gap");
  a_single_pulse: assert property (matchIrq && cmp != 16'h0000 |=> !matchIrq)
    else $error("match too wide");
endmodule // itm_chk

/* File: sim/tb_interval_timer_16bit.sv */
// Purpose: Self-checking bench for interval timer
// Assumes: Zero-wait slave
// Notes: Slow clocks are whole mclk multiples
module tb_interval_timer_16bit;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0, osc = 1'h0, sub = 1'h0, tick = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire resp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  wire [31:0] hrdata;
  wire hready, irq;
  int fail_count = 0, samples_checked = 0, n;
  int ex[8] = '{2, 4, 8, 128, 1024, 40, 48, 14};
  itm_interval_timer itm_interval_timer_i (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(resp), .watchTickIn(tick), .internalOscClk(osc), .subClk(sub), .matchIrq(irq));
  initial forever #20 mclk = ~mclk;
  initial
  begin
    #7;
    fork
      forever #60 osc = ~osc;
      forever #140 sub = ~sub;
      forever #400 tick = ~tick;
    join
  end
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tmo;
    fail_count++;
    print_verdict;
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic rdy;
    int k;
    k = 0;
    @(posedge mclk);
    while (hready !== 1'h1)
    begin
      if (++k > 50) tmo;
      @(posedge mclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  task automatic wirq;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      if (++n > 5000) tmo;
    end
    while (irq !== 1'h1);
  endtask
  task automatic t_reset;
    bus(1'h0, 8'h00, 32'h0);
    chk(r, 32'h0);
    bus(1'h0, 8'h04, 32'h0);
    chk(r, 32'h0);
    bus(1'h0, 8'h0C, 32'h0);
    chk(r, 32'h0);
    chk(resp, 32'h0);
  endtask
  task automatic t_narrow;
    bus(1'h1, 8'h04, 32'h0);
    bus(1'h1, 8'h00, 32'h3);
    hsize <= 3'h0;
    bus(1'h1, 8'h00, 32'h5);
    bus(1'h1, 8'h04, 32'h1);
    hsize <= 3'h2;
    bus(1'h0, 8'h00, 32'h0);
    chk(r, 32'h3);
    bus(1'h0, 8'h04, 32'h0);
    chk(r, 32'h1);
    bus(1'h1, 8'h04, 32'h0);
  endtask
  task automatic t_modes;
    for (int c = 0; c < 8; c++)
    begin
      bus(1'h1, 8'h04, c);
      bus(1'h1, 8'h00, 32'h1);
      bus(1'h1, 8'h04, 32'h80 | c);
      wirq;
      wirq;
      chk(n, ex[c]);
    end
  endtask
  task automatic t_same;
    bus(1'h1, 8'h04, 32'h0);
    bus(1'h1, 8'h00, 32'h3);
    bus(1'h1, 8'h04, 32'h80);
    wirq;
    bus(1'h1, 8'h04, 32'h80);
    wirq;
    chk(n, 32'h1);
    wirq;
    chk(n, 32'h4);
    bus(1'h0, 8'h08, 32'h0);
    chk(r, 32'h1);
    bus(1'h0, 8'h04, 32'h0);
    chk(r, 32'h80);
  endtask
  task automatic t_zero;
    bus(1'h1, 8'h04, 32'h0);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h04, 32'h80);
    wirq;
    wirq;
    chk(n, 32'h1);
  endtask
  task automatic t_stop;
    bus(1'h1, 8'h04, 32'h0);
    repeat (2) @(posedge mclk);
    repeat (40)
    begin
      @(posedge mclk);
      #1;
      chk(irq, 32'h0);
    end
    bus(1'h0, 8'h08, 32'h0);
    chk(r, 32'h0);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    nrst <= 1'h1;
    t_reset;
    t_narrow;
    t_modes;
    t_same;
    t_zero;
    t_stop;
    print_verdict;
  end
endmodule // tb_interval_timer_16bit
bind itm_interval_timer itm_chk itm_chk_i (.*);
